// ==== design/uct_pkg.sv ====
// package: register selects, field positions, reset values and carriers of the up-counter
package uct_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned REG_W = 8;
  localparam int unsigned SEL_W = 4;
  // first control register, upper nibble belongs to this counter
  localparam int unsigned C1_RUN_BIT = 7;
  localparam int unsigned C1_OVF_BIT = 6;
  localparam int unsigned C1_ONESHOT_BIT = 5;
  // second control register
  localparam int unsigned C2_WIDTH_BIT = 0;
  // prescaler mode register, upper nibble picks the count clock
  localparam int unsigned PRM_SEL_LSB = 4;
  localparam logic [SEL_W-1:0] CLK_SEL_EXT = 4'h7;
  // capture/compare control bits
  localparam int unsigned CCC_CLR_C_BIT = 5;
  localparam int unsigned CCC_CLR_B_BIT = 3;
  localparam int unsigned CCC_CAP_B_BIT = 2;
  // output control register, upper nibble drives this counter's pins
  localparam int unsigned TOC_EN_B_BIT = 7;
  localparam int unsigned TOC_LVL_B_BIT = 6;
  localparam int unsigned TOC_EN_A_BIT = 5;
  localparam int unsigned TOC_LVL_A_BIT = 4;
  // reset values
  localparam logic [REG_W-1:0] C1_RST = 8'h00;
  localparam logic [REG_W-1:0] C2_RST = 8'h00;
  localparam logic [REG_W-1:0] PRM_RST = 8'h11;
  localparam logic [REG_W-1:0] CCC_RST = 8'h10;
  localparam logic [REG_W-1:0] TOC_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] FULL_8 = 16'h00FF;
  localparam logic [CNT_W-1:0] FULL_16 = 16'hFFFF;

  typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH, EDGE_NONE} uct_edge_e;

  typedef enum logic [3:0] {SEL_CTRL1, SEL_CTRL2, SEL_PRM, SEL_CCC, SEL_TOC,
                            SEL_CMP_A, SEL_CCR_B, SEL_CAP_C, SEL_COUNT} uct_sel_e;

  // one software register write, 8-bit registers take the low byte
  typedef struct packed {
    logic en;
    uct_sel_e sel;
    logic [CNT_W-1:0] data;
  } uct_wr_s;

  // timer pins and pulses toward the output control and interrupt logic
  typedef struct packed {
    logic timer_out_a;
    logic timer_out_b;
    logic match_a_irq;
    logic match_b_irq;
    logic ovf_pulse;
    logic evt_irq;
    logic cap_irq;
  } uct_evt_s;
endpackage

// ==== design/uct_edge_det.sv ====
// two-flop synchroniser and valid-edge detector for one event pin
`timescale 1ns/10ps
module uct_edge_det
  import uct_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin,
  input wire uct_pkg::uct_edge_e mode,
  output logic edge_pulse
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic edge_p;
  } uct_ed_s;

  uct_ed_s q;
  uct_ed_s n;

  // only sync2 looks at sync1, the detector works on sync2 and prev
  always_comb
  begin
    n = q;
    n.sync1 = pin;
    n.sync2 = q.sync1;
    n.prev = q.sync2;
    case (mode)
      EDGE_RISE: n.edge_p = q.sync2 & ~q.prev;
      EDGE_FALL: n.edge_p = ~q.sync2 & q.prev;
      EDGE_BOTH: n.edge_p = q.sync2 ^ q.prev;
      default: n.edge_p = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= n;
  end

  assign edge_pulse = q.edge_p;
endmodule

// ==== design/uct_clk_sel.sv ====
// prescaler and selector: one-cycle count-clock enable from divider or event edge
`timescale 1ns/10ps
module uct_clk_sel
  import uct_pkg::*;
#(
  parameter int unsigned DIV_W = 8
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [uct_pkg::SEL_W-1:0] sel,
  input wire logic ext_edge,
  output logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
  } uct_cs_s;

  uct_cs_s q;
  uct_cs_s n;

  // low sel+1 bits set: the divider hits all-ones once per 2^(sel+1) cycles
  function automatic logic [DIV_W-1:0] div_mask(input logic [SEL_W-1:0] s);
    logic [DIV_W-1:0] m;
    m = '0;
    for (int i = 0; i < DIV_W; i++)
      m[i] = (i <= int'(s));
    return m;
  endfunction

  // codes past the divider width, other than the external select, give no clock, the counter just stands
  always_comb
  begin
    n = q;
    n.div = q.div + {{(DIV_W-1){1'b0}}, 1'b1};
    if (sel == CLK_SEL_EXT)
      n.tick = ext_edge;
    else if (int'(sel) < DIV_W)
      n.tick = ((q.div & div_mask(sel)) == div_mask(sel));
    else
      n.tick = 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= n;
  end

  assign tick = q.tick;
endmodule

// ==== design/uct_core.sv ====
// up-counter core: control registers, count, compare, capture and timer pins
// Summary of operation
// RL1: width-select bit of second control register picks 8-bit or 16-bit counting.
// RL2: counter adds one per count clock chosen by prescaler upper nibble.
// RL3: run bit set from zero loads zero on first count clock, then counts.
// RL4: run bit cleared zeroes the counter at once and stops capture and match.
// RL5: writing one to an already set run bit changes nothing.
// RL6: count clock at all-ones wraps to zero, sets overflow, pulses overflow out.
// RL7: overflow flag is cleared only by software writes.
// RL8: chip reset zeroes the counter and stops counting.
// RL9: output control register is 8-bit read/write, resets to zero.
// RL10: only the upper nibble of output control drives this timer's pins.
// RL11: enabled clear source holds the count, zero on next count clock.
// RL12: capture clear shows N plus one for a moment before zero.
// RL13: restart after stop always begins counting from zero.
// RL14: selecting external clock alone turns the counter into an event counter.
// RL15: event pin levels last four clocks, rate at most clock over eight.
// RL16: event pin edges give an interrupt pulse and a count clock together.
// RL17: one-shot select bit in first control register enables one-shot mode.
// RL18: one-shot full count sets overflow and holds all-ones.
// RL19: one-shot overflow cleared by software zeroes counter, counting resumes.
// RL20: one-shot compare equality raises the compare interrupt.
// RL21: in 16-bit width counter, compare and capture registers are 16 bits.
// RL22: disabled output pin drives the level given by its active-level bit.
// RL23: chip reset clears the first control register.
// RL24: every count clock is a one-cycle enable pulse on the system clock.
`timescale 1ns/10ps
module uct_core
  import uct_pkg::*;
#(
  parameter int unsigned DIV_W = 8
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire uct_pkg::uct_wr_s wr,
  input wire uct_pkg::uct_sel_e rd_sel,
  input wire logic event_count_input,
  input wire logic capture_irq_input,
  input wire uct_pkg::uct_edge_e evt_edge_mode,
  input wire uct_pkg::uct_edge_e cap_edge_mode,
  output logic [uct_pkg::CNT_W-1:0] rd_data,
  output logic [uct_pkg::CNT_W-1:0] wide_up_counter,
  output logic overflow_flag,
  output uct_pkg::uct_evt_s evt
);
  import uct_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_RUN, ST_HALT, ST_BLIP} uct_phase_e;

  typedef struct packed {
    uct_phase_e phase;
    logic [REG_W-1:0] ctrl1;
    logic [REG_W-1:0] ctrl2;
    logic [REG_W-1:0] prm;
    logic [REG_W-1:0] ccc;
    logic [REG_W-1:0] timer_output_control;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] ccr_b;
    logic [CNT_W-1:0] cap_c;
    logic clr_pend;
    logic clr_cap;
    logic upd;
    logic tog_a;
    logic tog_b;
    logic [CNT_W-1:0] rd;
    uct_evt_s ev;
  } uct_state_s;

  localparam uct_state_s RST_VAL = '{phase: ST_IDLE, ctrl1: C1_RST, ctrl2: C2_RST,
                                     prm: PRM_RST, ccc: CCC_RST, timer_output_control: TOC_RST,
                                     cnt: CNT_ZERO, cmp_a: CNT_ZERO, ccr_b: CNT_ZERO,
                                     cap_c: CNT_ZERO, rd: CNT_ZERO, default: '0};

  uct_state_s q;
  uct_state_s n;
  logic tick;
  logic evt_edge;
  logic cap_edge;
  logic wr_c1;
  logic run_set;
  logic run_clr;
  logic ovf_clr;
  logic oneshot;
  logic wide;
  logic running;
  logic [CNT_W-1:0] full;

  // all-ones of the current width
  function automatic logic [CNT_W-1:0] full_val(input logic w);
    return w ? FULL_16 : FULL_8;
  endfunction

  // compare on the active width only, upper byte ignored in 8-bit mode
  function automatic logic same(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b,
                                input logic w);
    return ((a ^ b) & full_val(w)) == CNT_ZERO;
  endfunction

  // event pin feeds both the interrupt pulse and the external count clock
  uct_edge_det u_evt_edge (
    .clk(clk),
    .arst_n(arst_n),
    .pin(event_count_input),
    .mode(evt_edge_mode),
    .edge_pulse(evt_edge)
  );

  uct_edge_det u_cap_edge (
    .clk(clk),
    .arst_n(arst_n),
    .pin(capture_irq_input),
    .mode(cap_edge_mode),
    .edge_pulse(cap_edge)
  );

  // count clock arrives as a single-cycle enable
  uct_clk_sel #(.DIV_W(DIV_W)) u_clk_sel (
    .clk(clk),
    .arst_n(arst_n),
    .sel(q.prm[PRM_SEL_LSB +: SEL_W]), // RL2 RL14
    .ext_edge(evt_edge),
    .tick(tick) // RL24
  );

  // software control strobes, decoded from the write carrier
  assign wr_c1 = wr.en && (wr.sel == SEL_CTRL1);
  assign run_set = wr_c1 && wr.data[C1_RUN_BIT] && !q.ctrl1[C1_RUN_BIT]; // RL5
  assign run_clr = wr_c1 && !wr.data[C1_RUN_BIT] && q.ctrl1[C1_RUN_BIT];
  assign ovf_clr = wr_c1 && !wr.data[C1_OVF_BIT] && q.ctrl1[C1_OVF_BIT];
  assign oneshot = q.ctrl1[C1_ONESHOT_BIT]; // RL17
  assign wide = q.ctrl2[C2_WIDTH_BIT]; // RL1 RL21
  assign running = (q.phase == ST_RUN) || (q.phase == ST_BLIP);
  assign full = full_val(wide);

  always_comb
  begin
    n = q;
    n.ev.match_a_irq = 1'b0;
    n.ev.match_b_irq = 1'b0;
    n.ev.ovf_pulse = 1'b0;
    n.ev.cap_irq = cap_edge;
    n.ev.evt_irq = evt_edge; // RL16
    n.upd = 1'b0;

    // register writes; the overflow bit can only be written to zero
    if (wr.en)
    begin
      case (wr.sel)
        SEL_CTRL1:
        begin
          n.ctrl1 = wr.data[REG_W-1:0];
          n.ctrl1[C1_OVF_BIT] = q.ctrl1[C1_OVF_BIT] & wr.data[C1_OVF_BIT]; // RL7
        end
        SEL_CTRL2: n.ctrl2 = wr.data[REG_W-1:0];
        SEL_PRM: n.prm = wr.data[REG_W-1:0];
        SEL_CCC: n.ccc = wr.data[REG_W-1:0];
        SEL_TOC: n.timer_output_control = wr.data[REG_W-1:0]; // RL9
        SEL_CMP_A: n.cmp_a = wr.data;
        SEL_CCR_B:
        begin
          // capture mode owns the register, software writes are dropped
          if (!q.ccc[CCC_CAP_B_BIT])
            n.ccr_b = wr.data;
        end
        default: n.cmp_a = n.cmp_a;
      endcase
    end

    // match pulses fire once when the count settles on the compare value
    if (running && q.upd && same(q.cnt, q.cmp_a, wide))
      n.ev.match_a_irq = 1'b1; // RL20
    if (running && q.upd && !q.ccc[CCC_CAP_B_BIT] && same(q.cnt, q.ccr_b, wide))
    begin
      n.ev.match_b_irq = 1'b1;
      if (q.ccc[CCC_CLR_B_BIT])
      begin
        n.clr_pend = 1'b1; // RL11
        n.clr_cap = 1'b0;
      end
    end
    if (q.phase == ST_HALT && q.upd && same(q.cnt, q.cmp_a, wide))
      n.ev.match_a_irq = 1'b1; // RL20

    // captures only while counting; clear follows the next count clock
    if (running && cap_edge)
    begin
      n.cap_c = q.cnt & full; // RL21
      if (q.ccc[CCC_CLR_C_BIT])
      begin
        n.clr_pend = 1'b1; // RL11
        n.clr_cap = 1'b1;
      end
    end
    if (running && evt_edge && q.ccc[CCC_CAP_B_BIT])
    begin
      n.ccr_b = q.cnt & full;
      if (q.ccc[CCC_CLR_B_BIT])
      begin
        n.clr_pend = 1'b1;
        n.clr_cap = 1'b1;
      end
    end

    // count sequencer
    case (q.phase)
      ST_IDLE:
      begin
        if (run_set)
          n.phase = ST_ARM; // RL13
      end
      ST_ARM:
      begin
        if (tick)
        begin
          n.cnt = CNT_ZERO; // RL3 RL13
          n.upd = 1'b1;
          n.phase = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (tick && q.clr_pend && q.clr_cap)
        begin
          // the capture clear steps through N+1 for one cycle
          n.cnt = (q.cnt + CNT_ONE) & full; // RL12
          n.upd = 1'b1;
          n.clr_pend = 1'b0;
          n.phase = ST_BLIP;
        end
        else if (tick && q.clr_pend)
        begin
          n.cnt = CNT_ZERO; // RL11
          n.upd = 1'b1;
          n.clr_pend = 1'b0;
        end
        else if (tick && oneshot)
        begin
          n.cnt = (q.cnt + CNT_ONE) & full; // RL2
          n.upd = 1'b1;
          if (((q.cnt + CNT_ONE) & full) == full)
          begin
            n.ctrl1[C1_OVF_BIT] = 1'b1; // RL18
            n.phase = ST_HALT;
          end
        end
        else if (tick && (q.cnt & full) == full)
        begin
          n.cnt = CNT_ZERO; // RL6
          n.upd = 1'b1;
          n.ctrl1[C1_OVF_BIT] = 1'b1; // RL6
          n.ev.ovf_pulse = 1'b1;
        end
        else if (tick)
        begin
          n.cnt = (q.cnt + CNT_ONE) & full; // RL2
          n.upd = 1'b1;
        end
      end
      ST_BLIP:
      begin
        n.cnt = CNT_ZERO; // RL12
        n.upd = 1'b1;
        n.phase = ST_RUN;
      end
      ST_HALT:
      begin
        // a halted one-shot waits for software to drop the overflow flag
        if (ovf_clr)
        begin
          n.cnt = CNT_ZERO; // RL19
          n.phase = ST_RUN;
        end
      end
      default: n.phase = ST_IDLE;
    endcase

    // stop wins over the sequencer's count, phase and pending clear and acts without a count clock
    if (run_clr)
    begin
      n.cnt = CNT_ZERO; // RL4
      n.clr_pend = 1'b0;
      n.clr_cap = 1'b0;
      n.phase = ST_IDLE;
    end
    if (!running && !run_clr)
      n.clr_pend = 1'b0;

    // output toggles on match; a disabled pin shows its level bit
    if (n.ev.match_a_irq)
      n.tog_a = ~q.tog_a;
    if (n.ev.match_b_irq)
      n.tog_b = ~q.tog_b;
    if (!q.timer_output_control[TOC_EN_A_BIT])
      n.tog_a = 1'b0;
    if (!q.timer_output_control[TOC_EN_B_BIT])
      n.tog_b = 1'b0;
    n.ev.timer_out_a = q.timer_output_control[TOC_LVL_A_BIT] ^ q.tog_a; // RL10 RL22
    n.ev.timer_out_b = q.timer_output_control[TOC_LVL_B_BIT] ^ q.tog_b; // RL10 RL22

    // read port, registered; 8-bit registers sit in the low byte
    case (rd_sel)
      SEL_CTRL1: n.rd = {{(CNT_W-REG_W){1'b0}}, q.ctrl1};
      SEL_CTRL2: n.rd = {{(CNT_W-REG_W){1'b0}}, q.ctrl2};
      SEL_PRM: n.rd = {{(CNT_W-REG_W){1'b0}}, q.prm};
      SEL_CCC: n.rd = {{(CNT_W-REG_W){1'b0}}, q.ccc};
      SEL_TOC: n.rd = {{(CNT_W-REG_W){1'b0}}, q.timer_output_control};
      SEL_CMP_A: n.rd = q.cmp_a & full;
      SEL_CCR_B: n.rd = q.ccr_b & full;
      SEL_CAP_C: n.rd = q.cap_c & full;
      SEL_COUNT: n.rd = q.cnt & full;
      default: n.rd = CNT_ZERO;
    endcase
  end

  // chip reset: counter zero, stopped, first and second control and output control registers cleared
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= RST_VAL; // RL8 RL23
    else
      q <= n;
  end

  assign rd_data = q.rd;
  assign wide_up_counter = q.cnt;
  assign overflow_flag = q.ctrl1[C1_OVF_BIT];
  assign evt = q.ev;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_stop_zero;
    run_clr |=> (q.cnt == CNT_ZERO) && (q.phase == ST_IDLE);
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("stop did not zero counter"); // RL4

  property p_first_tick;
    (q.phase == ST_ARM) && tick && !run_clr |=> (q.cnt == CNT_ZERO) && running;
  endproperty
  a_first_tick: assert property (p_first_tick) else $error("first tick did not load zero"); // RL3

  property p_wrap;
    (q.phase == ST_RUN) && tick && !q.clr_pend && !oneshot && !run_clr &&
      ((q.cnt & full) == full)
      |=> (q.cnt == CNT_ZERO) && overflow_flag && q.ev.ovf_pulse;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap with overflow"); // RL6

  property p_ovf_sticky;
    overflow_flag && !wr_c1 |=> overflow_flag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow cleared by hardware"); // RL7

  property p_hold_clear;
    (q.phase == ST_RUN) && q.clr_pend && !tick && !run_clr |=> $stable(q.cnt);
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("count moved before clear"); // RL11

  property p_blip;
    (q.phase == ST_RUN) && tick && q.clr_pend && q.clr_cap && !run_clr
      |=> (q.cnt == (($past(q.cnt) + CNT_ONE) & full)) ##1 (q.cnt == CNT_ZERO);
  endproperty
  a_blip: assert property (p_blip) else $error("capture clear sequence wrong"); // RL12

  property p_halt;
    (q.phase == ST_HALT) && !ovf_clr && !run_clr |=> $stable(q.cnt) && overflow_flag;
  endproperty
  a_halt: assert property (p_halt) else $error("one-shot did not hold"); // RL18

  property p_resume;
    (q.phase == ST_HALT) && ovf_clr && !run_clr |=> (q.cnt == CNT_ZERO) && (q.phase == ST_RUN);
  endproperty
  a_resume: assert property (p_resume) else $error("one-shot did not restart"); // RL19

  property p_rerun;
    (q.phase == ST_RUN) && wr_c1 && wr.data[C1_RUN_BIT] && !tick && !q.clr_pend
      |=> $stable(q.cnt) && (q.phase == ST_RUN);
  endproperty
  a_rerun: assert property (p_rerun) else $error("rewrite of run disturbed count"); // RL5

  property p_fixed_pin;
    !q.timer_output_control[TOC_EN_A_BIT] ##1 !q.timer_output_control[TOC_EN_A_BIT]
      |=> evt.timer_out_a == $past(q.timer_output_control[TOC_LVL_A_BIT], 1);
  endproperty
  a_fixed_pin: assert property (p_fixed_pin) else $error("disabled pin not fixed"); // RL22
endmodule

// ==== verif/uct_evt_src.sv ====
// partner model: external event source driving the event count pin
`timescale 1ns/10ps
module uct_evt_src
(
  input wire logic clk,
  output logic pin
);
  // pin idles low between bursts, the pull-down level of the line
  initial pin = 1'b0;

  // each level held six clocks, so a period of twelve stays under clk/8
  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (6) @(posedge clk);
      #1 pin = 1'b1;
      repeat (6) @(posedge clk);
      #1 pin = 1'b0;
    end
  endtask
endmodule

// ==== verif/uct_core_tb.sv ====
// self-checking testbench of the up-counter core
`timescale 1ns/10ps
module uct_core_tb;
  import uct_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  uct_wr_s wr = '0;
  uct_sel_e rd_sel = SEL_CTRL1;
  logic cap_pin = 1'b0;
  uct_edge_e cap_mode = EDGE_NONE;
  uct_edge_e evt_mode = EDGE_RISE;
  logic [CNT_W-1:0] rd_data;
  logic [CNT_W-1:0] cnt;
  logic ovf;
  uct_evt_s evt;
  logic ev_pin;
  logic [CNT_W-1:0] prev_cnt = '0;
  logic [CNT_W-1:0] match_val = '0;
  int ovf_seen = 0;
  int evt_seen = 0;
  int match_seen = 0;
  int cap_seen = 0;
  int failures = 0;
  int samples_checked = 0;

  always #2.5 clk = ~clk;

  uct_core #(.DIV_W(4)) uut (.clk(clk), .arst_n(arst_n), .wr(wr), .rd_sel(rd_sel),
    .event_count_input(ev_pin), .capture_irq_input(cap_pin), .evt_edge_mode(evt_mode),
    .cap_edge_mode(cap_mode), .rd_data(rd_data), .wide_up_counter(cnt),
    .overflow_flag(ovf), .evt(evt));

  uct_evt_src src (.clk(clk), .pin(ev_pin));

  // sticky record of one-cycle pulses, so scenarios need not hit the exact cycle
  always @(posedge clk)
  begin
    if (evt.ovf_pulse === 1'b1) ovf_seen++;
    if (evt.evt_irq === 1'b1) evt_seen++;
    if (evt.cap_irq === 1'b1) cap_seen++;
    if (evt.match_a_irq === 1'b1)
    begin
      match_seen++;
      match_val = prev_cnt;
    end
    prev_cnt = cnt;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe, released after the taking edge
  task automatic wr_reg(input uct_sel_e s, input logic [CNT_W-1:0] d);
    @(posedge clk);
    #1 wr = '{1'b1, s, d};
    @(posedge clk);
    #1 wr.en = 1'b0;
  endtask

  // read data lands one edge after the select, checked after two
  task automatic rd_chk(input uct_sel_e s, input logic [CNT_W-1:0] exp);
    @(posedge clk);
    #1 rd_sel = s;
    repeat (2) @(posedge clk);
    #1 chk(rd_data, exp);
  endtask

  // bounded wait for a counter value; a miss ends the run
  task automatic wait_cnt(input logic [CNT_W-1:0] v, input int lim);
    int i;
    for (i = 0; i < lim && cnt !== v; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (cnt !== v)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, cnt, v);
      give_verdict();
    end
  endtask

  task automatic t_reset;
    rd_chk(SEL_CTRL1, 16'h0000);
    rd_chk(SEL_TOC, 16'h0000);
    chk(cnt, 16'h0000);
    chk({15'h0000, ovf}, 16'h0000);
  endtask

  task automatic t_run;
    wr_reg(SEL_PRM, 16'h0001);
    wr_reg(SEL_CTRL1, 16'h0080);
    wait_cnt(16'h0003, 20);
    wr_reg(SEL_CTRL1, 16'h0080);
    wait_cnt(16'h0006, 9);
    wr_reg(SEL_CTRL1, 16'h0000);
    chk(cnt, 16'h0000);
    repeat (10) @(posedge clk);
    #1 chk(cnt, 16'h0000);
  endtask

  task automatic t_wrap;
    ovf_seen = 0;
    wr_reg(SEL_CTRL1, 16'h0080);
    wait_cnt(16'h00FF, 600);
    wait_cnt(16'h0000, 4);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, ovf}, 16'h0001);
    chk(16'(ovf_seen), 16'h0001);
    wait_cnt(16'h00FF, 600);
    wait_cnt(16'h0000, 4);
    chk({15'h0000, ovf}, 16'h0001);
    wr_reg(SEL_CTRL1, 16'h0080);
    @(posedge clk);
    #1 chk({15'h0000, ovf}, 16'h0000);
    wr_reg(SEL_CTRL1, 16'h0000);
  endtask

  task automatic t_wide;
    wr_reg(SEL_CTRL2, 16'h0001);
    wr_reg(SEL_CMP_A, 16'h0102);
    rd_chk(SEL_CMP_A, 16'h0102);
    wr_reg(SEL_CTRL1, 16'h0080);
    wait_cnt(16'h0100, 600);
    wr_reg(SEL_CTRL1, 16'h0000);
    wr_reg(SEL_CTRL2, 16'h0000);
  endtask

  // match on the capture/compare register clears the count at the following tick
  task automatic t_clear;
    logic [CNT_W-1:0] top;
    top = '0;
    wr_reg(SEL_CCC, 16'h0018);
    wr_reg(SEL_CCR_B, 16'h0005);
    wr_reg(SEL_CTRL1, 16'h0080);
    repeat (100)
    begin
      @(posedge clk);
      if (cnt > top) top = cnt;
    end
    chk(top, 16'h0005);
    wr_reg(SEL_CTRL1, 16'h0000);
    wr_reg(SEL_CCC, 16'h0010);
  endtask

  // capture pin clear steps through N+1; the pin rises between ticks so N is known
  task automatic t_capture;
    cap_mode = EDGE_RISE;
    wr_reg(SEL_CCC, 16'h0030);
    wr_reg(SEL_CMP_A, 16'h0009);
    match_seen = 0;
    cap_seen = 0;
    wr_reg(SEL_CTRL1, 16'h0080);
    wait_cnt(16'h0003, 20);
    repeat (7) @(posedge clk);
    #1 cap_pin = 1'b1;
    repeat (8) @(posedge clk);
    #1 cap_pin = 1'b0;
    chk(match_val, 16'h0009);
    chk(16'(match_seen), 16'h0001);
    chk(16'(cap_seen), 16'h0001);
    rd_chk(SEL_CAP_C, 16'h0008);
    wr_reg(SEL_CTRL1, 16'h0000);
    wr_reg(SEL_CCC, 16'h0010);
  endtask

  task automatic t_oneshot;
    wr_reg(SEL_CMP_A, 16'h0010);
    match_seen = 0;
    wr_reg(SEL_CTRL1, 16'h00A0);
    wait_cnt(16'h00FF, 600);
    repeat (20) @(posedge clk);
    chk(cnt, 16'h00FF);
    chk({15'h0000, ovf}, 16'h0001);
    chk(match_val, 16'h0010);
    chk(16'(match_seen), 16'h0001);
    wr_reg(SEL_CTRL1, 16'h00A0);
    chk(cnt, 16'h0000);
    chk({15'h0000, ovf}, 16'h0000);
    wait_cnt(16'h0002, 10);
    wr_reg(SEL_CTRL1, 16'h0000);
  endtask

  // first edge only loads zero, so three edges leave a count of two
  task automatic t_event;
    wr_reg(SEL_PRM, 16'h0071);
    evt_seen = 0;
    wr_reg(SEL_CTRL1, 16'h0080);
    src.pulses(3);
    repeat (8) @(posedge clk);
    chk(cnt, 16'h0002);
    chk(16'(evt_seen), 16'h0003);
    wr_reg(SEL_CTRL1, 16'h0000);
    wr_reg(SEL_PRM, 16'h0001);
  endtask

  task automatic t_pins;
    wr_reg(SEL_TOC, 16'h0050);
    repeat (3) @(posedge clk);
    chk({14'h0000, evt.timer_out_a, evt.timer_out_b}, 16'h0003);
    wr_reg(SEL_TOC, 16'h000F);
    repeat (3) @(posedge clk);
    chk({14'h0000, evt.timer_out_a, evt.timer_out_b}, 16'h0000);
    rd_chk(SEL_TOC, 16'h000F);
  endtask

  // main sequence: reset held for twenty clocks, then each scenario in turn
  initial
  begin
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    t_reset();
    t_run();
    t_wrap();
    t_wide();
    t_clear();
    t_capture();
    t_oneshot();
    t_event();
    t_pins();
    give_verdict();
  end
endmodule
